// *** hdl/hpp_pkg.sv ***
// Constants and carrier types for the host processor bus port.
// Assumes one 40 MHz system clock and a synchronous active-high reset.
package hpp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;

  ////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int LO_MSB = 7;
  localparam int HI_LSB = 8;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
  localparam logic STYLE_DS = 1'b0;
  localparam logic STYLE_SEP = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Timing: synchroniser depth and clock period
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 25;

  ////////////////////////////////////////////////////////////////////////
  // Transfer state machine
  typedef enum logic [1:0] {
    HPP_IDLE = 2'b00,
    HPP_READ = 2'b01,
    HPP_WRITE = 2'b10
  } hpp_state_e;

  // Pins sampled from the processor side
  typedef struct packed {
    logic cs_n;
    logic rd_ds_n;
    logic wr_rw_n;
    logic ale;
    logic addr_mux_mode;
    logic bus_width_select;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hpp_pin_s;

  // Register access request towards the device core
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } hpp_req_s;

endpackage

// *** hdl/hpp_port.sv ***
// Host processor bus port: strobe decode, address latch, data and
// interrupt pin drivers. Assumes pins are asynchronous to clk and the
// core answers reg_rdata in the same cycle as the read request pulse.
//
// How it works
// - Device select low is required; strobes are ignored while select is high.
// - Separate-strobe style: read strobe returns addressed register on data bus.
// - Separate-strobe style: write strobe stores data bus into addressed register.
// - Data-strobe read: device drives valid data while strobe stays asserted.
// - Data-strobe style: one direction line chooses read or write.
// - Multiplexed mode: latch transparent while latch enable high, holds at fall.
// - Latch enable high after reset picks separate strobes; data-strobe style holds only until then.
// - Width select low gives 8-bit bus, high gives 16-bit bus.
// - Five-bit address, taken straight from pins in non-multiplexed mode.
// - Interrupt pin: push-pull either polarity, or open-drain.
// - Interrupt asserted while pending; released to high impedance in reset.
// - Open-drain interrupt only pulls low, allowing a shared wired line.
// - System reset forces every register except the pin synchronisers into its reset state.
// - In 16-bit mode general-purpose pins carry upper data byte.
`timescale 1ns/100ps

module hpp_port (
  input wire logic clk,
  input wire logic rst,
  input wire hpp_pkg::hpp_pin_s pin_in,
  output logic [hpp_pkg::BYTE_W-1:0] data_lo_out,
  output logic data_lo_oe,
  output logic [hpp_pkg::BYTE_W-1:0] data_hi_out,
  output logic data_hi_oe,
  output logic interrupt_request_out,
  output logic interrupt_request_oe,
  output hpp_pkg::hpp_req_s reg_req,
  input wire logic [hpp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq_pending,
  input wire logic irq_open_drain,
  input wire logic irq_active_high,
  input wire logic [hpp_pkg::BYTE_W-1:0] gpio_out,
  input wire logic [hpp_pkg::BYTE_W-1:0] gpio_oe,
  output logic [hpp_pkg::BYTE_W-1:0] gpio_in,
  output logic bus_style_sep
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  hpp_pkg::hpp_pin_s pin_s1_q;
  hpp_pkg::hpp_pin_s pin_s2_q;

  always_ff @(posedge clk) begin
    pin_s1_q <= pin_in;
    pin_s2_q <= pin_s1_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  hpp_pkg::hpp_state_e state_q;
  hpp_pkg::hpp_state_e state_d;
  hpp_pkg::hpp_req_s req_q;
  hpp_pkg::hpp_req_s req_d;
  logic style_q;
  logic [hpp_pkg::ADDR_W-1:0] addr_lat_q;
  logic [hpp_pkg::BYTE_W-1:0] data_lo_q;
  logic [hpp_pkg::BYTE_W-1:0] data_hi_q;
  logic data_lo_oe_q;
  logic data_hi_oe_q;
  logic [hpp_pkg::BYTE_W-1:0] gpio_in_q;
  logic irq_out_q;
  logic irq_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Strobe decode
  wire sel = ~pin_s2_q.cs_n;
  wire sep_rd = ~pin_s2_q.rd_ds_n;
  wire sep_wr = ~pin_s2_q.wr_rw_n;
  wire ds_on = ~pin_s2_q.rd_ds_n;
  wire ds_rd = ds_on & pin_s2_q.wr_rw_n;
  wire ds_wr = ds_on & ~pin_s2_q.wr_rw_n;
  wire rd_act = sel & (style_q ? sep_rd : ds_rd);
  wire wr_act = sel & (style_q ? sep_wr : ds_wr);
  wire wide = pin_s2_q.bus_width_select;

  // Address and write data selection
  wire [hpp_pkg::ADDR_W-1:0] addr_eff = pin_s2_q.addr_mux_mode ? addr_lat_q : pin_s2_q.addr;
  wire [hpp_pkg::BYTE_W-1:0] wd_hi = wide ? pin_s2_q.data[hpp_pkg::DATA_W-1:hpp_pkg::HI_LSB] : hpp_pkg::BYTE_RST;
  wire [hpp_pkg::DATA_W-1:0] wdata_eff = {wd_hi, pin_s2_q.data[hpp_pkg::LO_MSB:0]};

  // Upper pins: data byte in 16-bit mode, general-purpose otherwise
  wire hi_rd_drive = wide & (state_q == hpp_pkg::HPP_READ) & rd_act;
  wire lo_rd_drive = (state_q == hpp_pkg::HPP_READ) & rd_act;
  wire [hpp_pkg::BYTE_W-1:0] hi_d = wide ? reg_rdata[hpp_pkg::DATA_W-1:hpp_pkg::HI_LSB] : gpio_out;
  wire gpio_drv = ~wide & (|gpio_oe);

  // Interrupt drive
  wire irq_pp_level = irq_pending ~^ irq_active_high;
  wire irq_oe_d = irq_open_drain ? irq_pending : 1'b1;
  wire irq_out_d = irq_open_drain ? 1'b0 : irq_pp_level;

  ////////////////////////////////////////////////////////////////////////
  // Bus style and address latch
  always_ff @(posedge clk) begin
    if (rst) begin
      style_q <= hpp_pkg::STYLE_DS;
    end else if (pin_s2_q.ale) begin
      style_q <= hpp_pkg::STYLE_SEP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_lat_q <= hpp_pkg::ADDR_RST;
    end else if (pin_s2_q.ale) begin
      addr_lat_q <= pin_s2_q.addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer state machine
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    req_d.re = 1'b0;
    req_d.we = 1'b0;
    case (state_q)
      hpp_pkg::HPP_IDLE: begin
        if (rd_act) begin
          state_d = hpp_pkg::HPP_READ;
          req_d.addr = addr_eff;
          req_d.re = 1'b1;
        end else if (wr_act) begin
          state_d = hpp_pkg::HPP_WRITE;
          req_d.addr = addr_eff;
          req_d.wdata = wdata_eff;
        end
      end
      hpp_pkg::HPP_READ: begin
        if (!rd_act) begin
          state_d = hpp_pkg::HPP_IDLE;
        end
      end
      hpp_pkg::HPP_WRITE: begin
        if (wr_act) begin
          req_d.wdata = wdata_eff;
        end else begin
          state_d = hpp_pkg::HPP_IDLE;
          req_d.we = 1'b1;
        end
      end
      default: begin
        state_d = hpp_pkg::HPP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= hpp_pkg::HPP_IDLE;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data pin drivers
  always_ff @(posedge clk) begin
    if (rst) begin
      data_lo_oe_q <= 1'b0;
      data_hi_oe_q <= 1'b0;
    end else begin
      data_lo_oe_q <= lo_rd_drive;
      data_hi_oe_q <= hi_rd_drive | gpio_drv;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_lo_q <= hpp_pkg::BYTE_RST;
      data_hi_q <= hpp_pkg::BYTE_RST;
      gpio_in_q <= hpp_pkg::BYTE_RST;
    end else begin
      if (req_q.re) begin
        data_lo_q <= reg_rdata[hpp_pkg::LO_MSB:0];
      end
      if (req_q.re || !wide) begin
        data_hi_q <= hi_d;
      end
      if (!wide) begin
        gpio_in_q <= pin_s2_q.data[hpp_pkg::DATA_W-1:hpp_pkg::HI_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pin
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_out_q <= 1'b0;
      irq_oe_q <= 1'b0;
    end else begin
      irq_out_q <= irq_out_d;
      irq_oe_q <= irq_oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign data_lo_out = data_lo_q;
  assign data_lo_oe = data_lo_oe_q;
  assign data_hi_out = data_hi_q;
  assign data_hi_oe = data_hi_oe_q;
  assign interrupt_request_out = irq_out_q;
  assign interrupt_request_oe = irq_oe_q;
  assign reg_req = req_q;
  assign gpio_in = gpio_in_q;
  assign bus_style_sep = style_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_sel_gate;
    !sel |=> !req_q.re && !data_lo_oe_q;
  endproperty
  a_sel_gate: assert property (p_sel_gate) else $error("Access taken while deselected");

  property p_read_pulse;
    (state_q == hpp_pkg::HPP_IDLE && rd_act) |=> req_q.re ##1 !req_q.re;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("Read request not a single pulse");

  property p_write_pulse;
    (state_q == hpp_pkg::HPP_WRITE && !wr_act) |=> req_q.we ##1 (!req_q.we && state_q == hpp_pkg::HPP_IDLE);
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("Write not issued at strobe end");

  property p_read_data;
    $rose(data_lo_oe_q) |-> data_lo_out == $past(reg_rdata[hpp_pkg::LO_MSB:0]);
  endproperty
  a_read_data: assert property (p_read_data) else $error("Read data not from core");

  property p_ds_write;
    (state_q == hpp_pkg::HPP_IDLE && sel && !style_q && ds_wr) |=> state_q == hpp_pkg::HPP_WRITE;
  endproperty
  a_ds_write: assert property (p_ds_write) else $error("Direction line write not taken");

  property p_latch_hold;
    (pin_s2_q.addr_mux_mode && !pin_s2_q.ale) |=> $stable(addr_lat_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Address latch moved while closed");

  property p_style;
    pin_s2_q.ale |=> style_q;
  endproperty
  a_style: assert property (p_style) else $error("Latch enable high did not pick strobes");

  property p_wide_drive;
    ($past(wide) && data_hi_oe_q) |-> data_lo_oe_q;
  endproperty
  a_wide_drive: assert property (p_wide_drive) else $error("Upper byte driven outside read");

  property p_release;
    data_lo_oe_q |-> $past(rd_act) && $past(state_q) == hpp_pkg::HPP_READ;
  endproperty
  a_release: assert property (p_release) else $error("Data bus driven without read");

  property p_reset_state;
    disable iff (1'b0) rst |=> !data_lo_oe_q && !irq_oe_q && !req_q.we && !req_q.re;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("Pins not released in reset");

  property p_open_drain;
    irq_oe_q && $past(irq_open_drain) |-> !irq_out_q && $past(irq_pending);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Open-drain line driven high");

  property p_irq_level;
    !$past(rst) && !$past(irq_open_drain) |-> irq_oe_q && irq_out_q == ($past(irq_pending) ~^ $past(irq_active_high));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong");

endmodule // hpp_port

// *** verification/hpp_host_model.sv ***
// Host processor model driving the port pins.
// Assumes the bench resolves the shared data lines into bus.
`timescale 1ns/100ps
module hpp_host_model (
  input wire logic clk,
  input wire logic [15:0] bus,
  output hpp_pkg::hpp_pin_s pins
);
  logic sep, mux;
  initial begin
    pins = '1;
    pins.ale = 1'b0;
    pins.addr_mux_mode = 1'b0;
    sep = 1'b0;
    mux = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Straps
  task automatic cfg(input logic s, input logic w, input logic m);
    sep = s;
    mux = m;
    pins.ale = s & ~m;
    pins.bus_width_select = w;
    pins.addr_mux_mode = m;
  endtask
  task automatic hi(input logic [7:0] v);
    pins.data[15:8] = v;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // One transfer, strobe held until data is taken
  task automatic xfer(input logic sel, input logic wr, input logic [4:0] a,
                      input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clk);
    #2;
    pins.addr = a;
    if (mux) begin
      pins.data = {11'h000, a};
      pins.ale = 1'b1;
      repeat (3) @(posedge clk);
      #2;
      pins.ale = 1'b0;
      pins.data = ~pins.data;
      repeat (3) @(posedge clk);
      #2;
    end
    pins.cs_n = ~sel;
    pins.wr_rw_n = ~wr;
    pins.rd_ds_n = sep ? wr : 1'b0;
    if (wr) pins.data = wd;
    repeat (8) @(posedge clk);
    rd = bus;
    #2;
    pins.cs_n = 1'b1;
    pins.rd_ds_n = 1'b1;
    pins.wr_rw_n = 1'b1;
    pins.data = ~pins.data;
    repeat (8) @(posedge clk);
    #2;
  endtask
endmodule // hpp_host_model

// *** verification/host_processor_bus_port_tb.sv ***
// Bench for the host processor bus port with a register core model.
// Assumes hpp_pkg, hpp_port and hpp_host_model are compiled first.
`timescale 1ns/100ps
module host_processor_bus_port_tb;
  logic clk, rst, irq_pending, irq_open_drain, irq_active_high;
  logic [7:0] gpio_out, gpio_oe, gpio_in, dlo, dhi;
  logic dlo_oe, dhi_oe, irq_out, irq_oe, style, e;
  logic [15:0] reg_rdata, bus, rd;
  logic [15:0] mem [32];
  logic [15:0] exp_w [32];
  logic [20:0] last_w;
  hpp_pkg::hpp_pin_s host_pins, pin_in;
  hpp_pkg::hpp_req_s req;
  int error_cnt = 0;
  int compares = 0;
  int we_cnt = 0;
  // Rows: width16, write, address, data
  localparam logic [22:0] ROWS [7] = '{{2'b11, 5'h00, 16'ha55a}, {2'b11, 5'h1f, 16'h1234},
    {2'b10, 5'h00, 16'h0000}, {2'b10, 5'h1f, 16'h0000}, {2'b01, 5'h05, 16'hbeef},
    {2'b00, 5'h05, 16'h0000}, {2'b10, 5'h05, 16'h0000}};
  ////////////////////////////////////////////////////////////////////////
  // Wiring, core model
  assign bus = {dhi_oe ? dhi : host_pins.data[15:8], dlo_oe ? dlo : host_pins.data[7:0]};
  always_comb begin
    pin_in = host_pins;
    pin_in.data = bus;
    if (host_pins.addr_mux_mode) pin_in.addr = bus[4:0];
  end
  always @(posedge clk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
      last_w <= {req.addr, req.wdata};
      we_cnt <= we_cnt + 1;
    end
  end
  // Core answers combinationally while the read pulse stands
  assign reg_rdata = mem[req.addr];
  hpp_host_model u_host (.clk(clk), .bus(bus), .pins(host_pins));
  hpp_port u_dut (.clk(clk), .rst(rst), .pin_in(pin_in), .data_lo_out(dlo), .data_lo_oe(dlo_oe),
    .data_hi_out(dhi), .data_hi_oe(dhi_oe), .interrupt_request_out(irq_out),
    .interrupt_request_oe(irq_oe), .reg_req(req), .reg_rdata(reg_rdata), .irq_pending(irq_pending),
    .irq_open_drain(irq_open_drain), .irq_active_high(irq_active_high), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .gpio_in(gpio_in), .bus_style_sep(style));
  ////////////////////////////////////////////////////////////////////////
  // Helpers
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [20:0] x, input logic [20:0] g);
    compares++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_rst(input logic s);
    @(posedge clk);
    #2;
    u_host.cfg(s, 1'b1, 1'b0);
    rst = 1'b1;
    repeat (16) @(posedge clk);
    chk("irq oe", 0, irq_oe);
    chk("oe", 0, {dlo_oe, dhi_oe, req.we, req.re});
    #2;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    chk("style", s, style);
  endtask
  task automatic rows;
    logic w16, wr;
    logic [4:0] a;
    logic [15:0] wd, msk;
    for (int i = 0; i < 7; i++) begin
      {w16, wr, a, wd} = ROWS[i];
      msk = w16 ? 16'hffff : 16'h00ff;
      u_host.cfg(style, w16, 1'b0);
      u_host.xfer(1'b1, wr, a, wd, rd);
      if (wr) begin
        exp_w[a] = wd & msk;
        chk("write", {a, exp_w[a]}, last_w);
      end else begin
        chk("read", exp_w[a] & msk, rd & msk);
      end
      chk("idle oe", 0, dlo_oe);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    {irq_pending, irq_open_drain, irq_active_high} = 3'b000;
    gpio_out = 8'h00;
    gpio_oe = 8'h00;
    do_rst(1'b0);
    rows();
    do_rst(1'b1);
    rows();
    u_host.xfer(1'b0, 1'b1, 5'h03, 16'h0f0f, rd);
    chk("deselected", {5'h05, 16'h00ef}, last_w);
    chk("write count", 21'(6), 21'(we_cnt));
    u_host.cfg(1'b1, 1'b1, 1'b1);
    u_host.xfer(1'b1, 1'b1, 5'h0a, 16'h77aa, rd);
    chk("latched write", {5'h0a, 16'h77aa}, last_w);
    u_host.xfer(1'b1, 1'b0, 5'h0a, 16'h0000, rd);
    chk("latched read", 21'h077aa, {5'h00, rd});
    u_host.cfg(1'b1, 1'b0, 1'b0);
    gpio_oe = 8'hff;
    gpio_out = 8'h5a;
    u_host.hi(8'hc3);
    repeat (4) @(posedge clk);
    chk("gpio drive", 9'h15a, {dhi_oe, dhi});
    #2;
    gpio_oe = 8'h00;
    repeat (5) @(posedge clk);
    chk("gpio in", 8'hc3, gpio_in);
    for (int i = 0; i < 8; i++) begin
      #2;
      {irq_pending, irq_open_drain, irq_active_high} = 3'(i);
      repeat (3) @(posedge clk);
      e = irq_open_drain ? irq_pending : 1'b1;
      chk("irq", {e, irq_open_drain ? 1'b0 : ~(irq_pending ^ irq_active_high)}, {irq_oe, irq_out});
    end
    do_rst(1'b0);
    stop_test();
  end
  initial begin
    #2000000;
    error_cnt++;
    stop_test();
  end
endmodule // host_processor_bus_port_tb
